// ### logic/obcfg_top.sv
// Bank B and Bank C output configuration registers with pin or register control.
// Assumes a byte register port from the serial configuration controller on mclk.
`timescale 1ns/10ps
module obcfg_top (
	input wire logic mclk,
	input wire logic sys_rst,
	input obcfg_pkg::obcfg_req_type reg_req,
	output logic [7:0] reg_rdata,
	input wire logic commit_update,
	input wire logic [1:0] bank_b_select_pins,
	input wire logic [1:0] bank_c_select_pins,
	output obcfg_pkg::obcfg_bank_type bank_b_state,
	output obcfg_pkg::obcfg_bank_type bank_c_state
);
	// ----------------------------------------
	// Storage, index 0 is Bank B, 1 is Bank C
	// ----------------------------------------
	logic [5:0] written_code [2];
	logic [5:0] active_code [2];
	logic bank_power_down [2];
	logic config_source [2];
	logic [3:0] out_power_down [2];
	logic [3:0] out_style [2];
	logic [7:0] out_amplitude [2];
	logic [1:0] pins_meta [2];
	logic [1:0] pins_sync [2];
	obcfg_pkg::obcfg_bank_type next_state [2];
	logic [1:0] pins_raw [2];
	logic [7:0] bank_base [2];
	logic [3:0] lane_used [2];

	assign pins_raw[0] = bank_b_select_pins;
	assign pins_raw[1] = bank_c_select_pins;
	assign bank_base[0] = obcfg_pkg::BANK_B_BASE;
	assign bank_base[1] = obcfg_pkg::BANK_C_BASE;
	assign lane_used[0] = 4'hf;
	assign lane_used[1] = 4'h3;

	genvar k;
	genvar i;
	generate
		for (k = 0; k < 2; k++) begin : g_bank
			// ----------------------------------------
			// Pin synchroniser
			// ----------------------------------------
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					pins_meta[k] <= 2'h0;
					pins_sync[k] <= 2'h0;
				end else begin
					pins_meta[k] <= pins_raw[k];
					pins_sync[k] <= pins_meta[k];
				end
			end

			// ----------------------------------------
			// Divider code, pending then active
			// ----------------------------------------
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					written_code[k] <= obcfg_pkg::DIVIDE_RESET;
				end else if (reg_req.write && reg_req.addr == bank_base[k] + obcfg_pkg::OFS_DIVIDE) begin
					written_code[k] <= reg_req.wdata[obcfg_pkg::DIVIDE_MSB:0];
				end
			end

			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					active_code[k] <= obcfg_pkg::DIVIDE_RESET;
				end else if (commit_update) begin
					active_code[k] <= written_code[k];
				end
			end

			// ----------------------------------------
			// Bank power-down and source select
			// ----------------------------------------
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					bank_power_down[k] <= obcfg_pkg::BANK_PD_RESET;
					config_source[k] <= obcfg_pkg::SOURCE_RESET;
				end else if (reg_req.write && reg_req.addr == bank_base[k] + obcfg_pkg::OFS_POWER_SOURCE) begin
					bank_power_down[k] <= reg_req.wdata[obcfg_pkg::BANK_PD_BIT];
					config_source[k] <= reg_req.wdata[obcfg_pkg::SOURCE_BIT];
				end
			end

			// ----------------------------------------
			// Per-output controls
			// ----------------------------------------
			for (i = 0; i < obcfg_pkg::MAX_OUTPUTS; i++) begin : g_out
				always_ff @(posedge mclk) begin
					if (sys_rst) begin
						out_power_down[k][i] <= obcfg_pkg::OUT_PD_RESET;
						out_style[k][i] <= obcfg_pkg::OUT_STYLE_RESET;
						out_amplitude[k][2 * i +: 2] <= obcfg_pkg::OUT_AMP_RESET;
					end else if (reg_req.write && lane_used[k][i]
							&& reg_req.addr == bank_base[k] + obcfg_pkg::OFS_OUTPUT0 + 8'(i)) begin
						out_power_down[k][i] <= reg_req.wdata[obcfg_pkg::OUT_PD_BIT];
						out_style[k][i] <= reg_req.wdata[obcfg_pkg::OUT_STYLE_BIT];
						out_amplitude[k][2 * i +: 2] <= reg_req.wdata[obcfg_pkg::OUT_AMP_MSB:0];
					end
				end
			end

			// ----------------------------------------
			// Live setting selection
			// ----------------------------------------
			obcfg_bank_select u_select (
				.config_source(config_source[k]),
				.select_pins(pins_sync[k]),
				.reg_power_down(bank_power_down[k]),
				.active_code(active_code[k]),
				.reg_out_power_down(out_power_down[k]),
				.reg_out_style(out_style[k]),
				.reg_out_amplitude(out_amplitude[k]),
				.lane_used(lane_used[k]),
				.live(next_state[k])
			);
		end
	endgenerate

	// ----------------------------------------
	// Registered bank outputs
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bank_b_state <= '0;
			bank_c_state <= '0;
		end else begin
			bank_b_state <= next_state[0];
			bank_c_state <= next_state[1];
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	function automatic logic [7:0] read_byte(input logic [7:0] addr, input int b);
		logic [7:0] d;
		logic [7:0] ofs;
		d = obcfg_pkg::RESERVED_READ;
		ofs = addr - bank_base[b];
		if (ofs == obcfg_pkg::OFS_DIVIDE) begin
			d[obcfg_pkg::DIVIDE_MSB:0] = written_code[b];
		end else if (ofs == obcfg_pkg::OFS_POWER_SOURCE) begin
			d[obcfg_pkg::BANK_PD_BIT] = bank_power_down[b];
			d[obcfg_pkg::SOURCE_BIT] = config_source[b];
		end else begin
			for (int j = 0; j < obcfg_pkg::MAX_OUTPUTS; j++) begin
				if (lane_used[b][j] && ofs == obcfg_pkg::OFS_OUTPUT0 + 8'(j)) begin
					d[obcfg_pkg::OUT_PD_BIT] = out_power_down[b][j];
					d[obcfg_pkg::OUT_STYLE_BIT] = out_style[b][j];
					d[obcfg_pkg::OUT_AMP_MSB:0] = out_amplitude[b][2 * j +: 2];
				end
			end
		end
		return d;
	endfunction

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.read) begin
			if (reg_req.addr >= obcfg_pkg::BANK_C_BASE) begin
				reg_rdata <= read_byte(reg_req.addr, 1);
			end else if (reg_req.addr >= obcfg_pkg::BANK_B_BASE) begin
				reg_rdata <= read_byte(reg_req.addr, 0);
			end else begin
				reg_rdata <= obcfg_pkg::RESERVED_READ;
			end
		end
	end
endmodule

// ### logic/obcfg_pkg.sv
// Package for the Bank B / Bank C output configuration registers.
// Assumes a byte-wide register port fed by the device's serial configuration controller.
package obcfg_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] BANK_B_BASE = 8'h18;
	localparam logic [7:0] BANK_C_BASE = 8'h20;
	localparam logic [7:0] OFS_DIVIDE = 8'h00;
	localparam logic [7:0] OFS_POWER_SOURCE = 8'h02;
	localparam logic [7:0] OFS_OUTPUT0 = 8'h04;
	localparam int BANK_B_OUTPUTS = 4;
	localparam int BANK_C_OUTPUTS = 2;
	localparam int MAX_OUTPUTS = 4;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DIVIDE_MSB = 5;
	localparam int BANK_PD_BIT = 7;
	localparam int SOURCE_BIT = 0;
	localparam int OUT_PD_BIT = 7;
	localparam int OUT_STYLE_BIT = 2;
	localparam int OUT_AMP_MSB = 1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [5:0] DIVIDE_RESET = 6'h0d;
	localparam logic BANK_PD_RESET = 1'h0;
	localparam logic SOURCE_RESET = 1'h0;
	localparam logic OUT_PD_RESET = 1'h0;
	localparam logic OUT_STYLE_RESET = 1'h0;
	localparam logic [1:0] OUT_AMP_RESET = 2'h0;
	localparam logic [7:0] RESERVED_READ = 8'h00;

	// ----------------------------------------
	// Pin-control presets, one divide code per pin pattern
	// ----------------------------------------
	localparam logic [23:0] PIN_DIVIDE_CODES = {6'h12, 6'h0d, 6'h0a, 6'h04};
	localparam logic PIN_STYLE = 1'h0;
	localparam logic [1:0] PIN_AMP = 2'h0;
	localparam logic PIN_POWER_DOWN = 1'h0;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
	} obcfg_req_type;

	typedef struct packed {
		logic power_down;
		logic [5:0] divide_code;
		logic [7:0] divide_ratio;
		logic [3:0] out_power_down;
		logic [3:0] out_style;
		logic [7:0] out_amplitude;
	} obcfg_bank_type;

	// Divide code to integer ratio, 0 for reserved codes
	function automatic logic [7:0] divide_ratio(input logic [5:0] code);
		logic [7:0] r;
		r = 8'h00;
		unique case (code)
			6'h01: r = 8'd1;
			6'h02: r = 8'd2;
			6'h03: r = 8'd3;
			6'h04: r = 8'd4;
			6'h05: r = 8'd5;
			6'h06: r = 8'd6;
			6'h07: r = 8'd8;
			6'h08: r = 8'd9;
			6'h09: r = 8'd10;
			6'h0a: r = 8'd12;
			6'h0b: r = 8'd14;
			6'h0c: r = 8'd15;
			6'h0d: r = 8'd16;
			6'h0e: r = 8'd18;
			6'h0f: r = 8'd20;
			6'h10: r = 8'd21;
			6'h11: r = 8'd22;
			6'h12: r = 8'd24;
			6'h13: r = 8'd25;
			6'h14: r = 8'd27;
			6'h15: r = 8'd28;
			6'h16: r = 8'd30;
			6'h17: r = 8'd32;
			6'h18: r = 8'd33;
			6'h19: r = 8'd35;
			6'h1a: r = 8'd36;
			6'h1b: r = 8'd40;
			6'h1c: r = 8'd42;
			6'h1d: r = 8'd44;
			6'h1e: r = 8'd45;
			6'h1f: r = 8'd48;
			6'h20: r = 8'd50;
			6'h21: r = 8'd54;
			6'h22: r = 8'd55;
			6'h23: r = 8'd56;
			6'h24: r = 8'd60;
			6'h25: r = 8'd64;
			6'h26: r = 8'd66;
			6'h27: r = 8'd70;
			6'h28: r = 8'd72;
			6'h29: r = 8'd80;
			6'h2a: r = 8'd84;
			6'h2b: r = 8'd88;
			6'h2c: r = 8'd90;
			6'h2d: r = 8'd96;
			6'h2e: r = 8'd100;
			6'h2f: r = 8'd108;
			6'h30: r = 8'd110;
			6'h31: r = 8'd120;
			6'h32: r = 8'd120;
			6'h33: r = 8'd128;
			6'h34: r = 8'd132;
			6'h35: r = 8'd140;
			6'h36: r = 8'd144;
			6'h37: r = 8'd160;
			6'h38: r = 8'd176;
			6'h39: r = 8'd180;
			6'h3a: r = 8'd200;
			6'h3b: r = 8'd220;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

endpackage

// ### logic/obcfg_bank_select.sv
// One output bank: chooses pin presets or register fields as the live setting; per-output power-downs are register fields unless bank power-down sets them.
// Assumes select pins are already synchronised and register fields come from flops.
`timescale 1ns/10ps
module obcfg_bank_select (
	input wire logic config_source,
	input wire logic [1:0] select_pins,
	input wire logic reg_power_down,
	input wire logic [5:0] active_code,
	input wire logic [3:0] reg_out_power_down,
	input wire logic [3:0] reg_out_style,
	input wire logic [7:0] reg_out_amplitude,
	input wire logic [3:0] lane_used,
	output obcfg_pkg::obcfg_bank_type live
);
	logic [5:0] pin_code;

	assign pin_code = obcfg_pkg::PIN_DIVIDE_CODES[6 * select_pins +: 6];

	always_comb begin
		live = '0;
		if (config_source) begin
			live.divide_code = active_code;
			live.power_down = reg_power_down;
			live.out_power_down = reg_out_power_down & lane_used;
			live.out_style = reg_out_style & lane_used;
			live.out_amplitude = reg_out_amplitude;
		end else begin
			live.divide_code = pin_code;
			live.power_down = obcfg_pkg::PIN_POWER_DOWN;
			live.out_power_down = reg_out_power_down & lane_used;
			live.out_style = {4{obcfg_pkg::PIN_STYLE}} & lane_used;
			live.out_amplitude = {4{obcfg_pkg::PIN_AMP}};
		end
		live.divide_ratio = obcfg_pkg::divide_ratio(live.divide_code);
		if (live.power_down) begin
			live.out_power_down = lane_used;
			live.divide_ratio = 8'h00;
		end
		for (int i = 0; i < obcfg_pkg::MAX_OUTPUTS; i++) begin
			if (!lane_used[i]) begin
				live.out_amplitude[2 * i +: 2] = 2'h0;
			end
		end
	end
endmodule

// ### bench/obcfg_assertions.sv
// Checker: port-level properties of the Bank B/C configuration block.
// Assumes it is bound to obcfg_top; shadows the Bank C divider and source writes.
`timescale 1ns/10ps
module obcfg_assertions (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire obcfg_pkg::obcfg_req_type reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic commit_update,
	input wire logic [1:0] bank_b_select_pins,
	input wire logic [1:0] bank_c_select_pins,
	input wire obcfg_pkg::obcfg_bank_type bank_b_state,
	input wire obcfg_pkg::obcfg_bank_type bank_c_state
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [5:0] c_pend;
	logic [5:0] c_act;
	logic c_src;
	// ----------------------------------------
	// Shadow of Bank C pending/active code
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			c_pend <= obcfg_pkg::DIVIDE_RESET;
			c_act <= obcfg_pkg::DIVIDE_RESET;
			c_src <= 1'h0;
		end else begin
			if (reg_req.write && reg_req.addr == 8'h20) c_pend <= reg_req.wdata[5:0];
			if (reg_req.write && reg_req.addr == 8'h22) c_src <= reg_req.wdata[0];
			if (commit_update) c_act <= c_pend;
		end
	end
	sequence s_c_div_read;
		reg_req.read && reg_req.addr == 8'h20;
	endsequence
	a_reset_clear: assert property (disable iff (1'h0) sys_rst |=>
		reg_rdata == 8'h00 && bank_b_state == '0 && bank_c_state == '0) else $error("state not clear after reset");
	a_b_bank_off: assert property (bank_b_state.power_down |->
		bank_b_state.divide_ratio == 8'h00 && bank_b_state.out_power_down == 4'hf) else $error("Bank B not off");
	a_c_bank_off: assert property (bank_c_state.power_down |->
		bank_c_state.divide_ratio == 8'h00 && bank_c_state.out_power_down[1:0] == 2'h3) else $error("Bank C not off");
	a_c_spare_lanes: assert property ({bank_c_state.out_power_down[3:2],
		bank_c_state.out_style[3:2], bank_c_state.out_amplitude[7:4]} == 8'h00) else $error("Bank C spare lanes set");
	a_ratio_reserved: assert property (bank_c_state.divide_code == 6'h00 ||
		bank_c_state.divide_code > 6'h3b |-> bank_c_state.divide_ratio == 8'h00) else $error("reserved code ratio");
	a_c_div_read: assert property (s_c_div_read |=>
		reg_rdata[5:0] == $past(c_pend)) else $error("divider read wrong");
	a_c_active_code: assert property (c_src |=> bank_c_state.power_down ||
		bank_c_state.divide_code == $past(c_act)) else $error("active code not committed value");
	a_c_pin_mode: assert property (!c_src |=>
		{bank_c_state.out_style[1:0], bank_c_state.out_amplitude[3:0]} == 6'h00) else $error("pin mode style");
endmodule

// ### bench/obcfg_host.sv
// Partner: host that writes and reads configuration bytes.
// Assumes the block takes a request on the rising edge of mclk.
`timescale 1ns/10ps
module obcfg_host (
	input wire logic mclk,
	input wire logic [7:0] reg_rdata,
	output obcfg_pkg::obcfg_req_type reg_req
);
	initial reg_req = '0;
	// Reserved bits zero: callers pass zeros there
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{addr: a, wdata: d, write: 1'h1, read: 1'h0};
		@(posedge mclk);
		reg_req <= '{addr: ~a, wdata: ~d, write: 1'h0, read: 1'h0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{addr: a, wdata: 8'h5a, write: 1'h0, read: 1'h1};
		@(posedge mclk);
		reg_req <= '{addr: ~a, wdata: 8'ha5, write: 1'h0, read: 1'h0};
		#1 d = reg_rdata;
	endtask
	// Outputs off too: per-output power-downs before the bank
	task automatic bank_off(input logic [7:0] base, input int n);
		for (int i = 0; i < n; i++) wr(base + 8'h04 + 8'(i), 8'h80);
		wr(base + 8'h02, 8'h81);
	endtask
endmodule

// ### bench/obcfg_bench.sv
// Testbench: drives pins, commit strobe and host traffic, checks live bank state.
// Assumes obcfg_top with its byte register port on a 10 MHz mclk.
`timescale 1ns/10ps
module obcfg_bench;
	logic mclk;
	logic sys_rst;
	logic commit_update;
	logic [1:0] bank_b_select_pins;
	logic [1:0] bank_c_select_pins;
	logic [7:0] reg_rdata;
	logic [7:0] rv;
	obcfg_pkg::obcfg_req_type reg_req;
	obcfg_pkg::obcfg_bank_type b;
	obcfg_pkg::obcfg_bank_type c;
	int bad_count;
	int n_tests;
	obcfg_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.commit_update(commit_update), .bank_b_select_pins(bank_b_select_pins),
		.bank_c_select_pins(bank_c_select_pins), .bank_b_state(b), .bank_c_state(c));
	obcfg_host i_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_req(reg_req));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		i_host.rd(a, rv);
		chk(rv & m, e);
	endtask
	task commit;
		@(posedge mclk) commit_update <= 1'h1;
		@(posedge mclk) commit_update <= 1'h0;
	endtask
	task do_reset;
		@(posedge mclk) sys_rst <= 1'h1;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'h0;
	endtask
	task close_out;
		if (bad_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		for (int i = 0; i < 2; i++) begin
			rdchk(8'h18 + 8'(8 * i), 8'h3f, 8'h0d);
			rdchk(8'h1a + 8'(8 * i), 8'h81, 8'h00);
			for (int j = 0; j < 4 - 2 * i; j++) rdchk(8'h1c + 8'(8 * i + j), 8'h87, 8'h00);
		end
	endtask
	task t_pins;
		logic [7:0] ratio [4];
		ratio = '{8'h04, 8'h0c, 8'h10, 8'h18};
		// Register fields that pin mode must ignore
		i_host.wr(8'h1a, 8'h80);
		i_host.wr(8'h1c, 8'h06);
		i_host.wr(8'h24, 8'h06);
		for (int p = 0; p < 4; p++) begin
			bank_b_select_pins <= 2'(p);
			bank_c_select_pins <= 2'(p);
			settle(4);
			chk({2'h0, c.divide_code}, {2'h0, obcfg_pkg::PIN_DIVIDE_CODES[6 * p +: 6]});
			chk(b.divide_ratio, ratio[p]);
			chk({b.power_down, b.out_style, 3'h0}, 8'h00);
			chk(b.out_amplitude, 8'h00);
			chk({c.out_style, c.out_amplitude[3:0]}, 8'h00);
		end
	endtask
	task t_regs;
		i_host.wr(8'h1c, 8'h04);
		i_host.wr(8'h1d, 8'h01);
		i_host.wr(8'h1e, 8'h02);
		i_host.wr(8'h1f, 8'h80);
		i_host.wr(8'h1a, 8'h01);
		i_host.wr(8'h24, 8'h06);
		i_host.wr(8'h25, 8'h81);
		i_host.wr(8'h22, 8'h01);
		settle(2);
		chk({b.out_power_down, b.out_style}, 8'h81);
		chk(b.out_amplitude, 8'h24);
		chk(b.divide_ratio, 8'h10);
		chk({c.out_power_down, c.out_style}, 8'h21);
		chk(c.out_amplitude, 8'h06);
	endtask
	task t_defer;
		i_host.wr(8'h20, 8'h3b);
		i_host.wr(8'h18, 8'h01);
		settle(3);
		chk(c.divide_ratio, 8'h10);
		rdchk(8'h20, 8'h3f, 8'h3b);
		commit;
		settle(2);
		chk(c.divide_ratio, 8'hdc);
		chk(b.divide_ratio, 8'h01);
		i_host.wr(8'h20, 8'h3c);
		commit;
		settle(2);
		chk(c.divide_ratio, 8'h00);
	endtask
	task t_off;
		i_host.wr(8'h20, 8'h02);
		commit;
		i_host.bank_off(8'h18, 4);
		i_host.bank_off(8'h20, 2);
		settle(2);
		chk({6'h0, b.power_down, c.power_down}, 8'h03);
		chk(b.divide_ratio | c.divide_ratio, 8'h00);
		chk({b.out_power_down, c.out_power_down}, 8'hf3);
		i_host.wr(8'h23, 8'h00);
		i_host.wr(8'h26, 8'h00);
		rdchk(8'h22, 8'h81, 8'h81);
	endtask
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		close_out;
	end
	initial begin
		sys_rst = 1'h1;
		commit_update = 1'h0;
		bank_b_select_pins = 2'h0;
		bank_c_select_pins = 2'h0;
		bad_count = 0;
		n_tests = 0;
		do_reset;
		t_reset;
		t_pins;
		t_regs;
		t_defer;
		t_off;
		do_reset;
		t_reset;
		close_out;
	end
endmodule
bind obcfg_top obcfg_assertions u_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .commit_update(commit_update), .bank_b_select_pins(bank_b_select_pins),
	.bank_c_select_pins(bank_c_select_pins), .bank_b_state(bank_b_state), .bank_c_state(bank_c_state));
